// File: verilog/bdcr_pkg.sv
// Package: register map, field layout and reset values of the config bank
package bdcr_pkg;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 16;
    localparam int NUM_OUT = 6;
    localparam logic [9:0] SUPPLY_SEL_OFS = 10'h288;
    localparam logic [9:0] SHORT_CFG_OFS = 10'h28a;
    localparam logic [9:0] STATE_MON_OFS = 10'h2a4;
    localparam logic [9:0] IN_DUTY_OFS = 10'h2a6;
    localparam logic [9:0] OUT_DUTY_OFS = 10'h2a8;
    localparam logic [9:0] OUT_CUR_OFS = 10'h2aa;
    localparam logic [9:0] BOOST_MON_OFS = 10'h2ac;
    localparam logic [9:0] STRAP_MON_OFS = 10'h2ae;
    localparam logic [15:0] SUPPLY_SEL_RST = 16'h01c0;
    localparam logic [15:0] SHORT_CFG_RST = 16'h2882;
    localparam int EXT_SEL_LSB = 10;
    localparam int THR_LSB = 9;
    localparam int THR_W = 3;
    localparam int STATE_W = 5;
    localparam int CUR_W = 12;
    localparam int BOOST_W = 11;
    localparam int LAYOUT_LSB = 0;
    localparam int SWRATE_LSB = 3;
    localparam int DIMRATE_LSB = 6;
    localparam int CODE3_W = 3;
    // Threshold code 4 selects 4.2 V; code table in volts*10: 26..60
    localparam logic [15:0] READ_ZERO = 16'h0000;
endpackage

// File: verilog/bdcr_regs.sv
// Configuration and diagnostic register bank of the backlight driver
`timescale 1ns/10ps
module bdcr_regs
#(
    parameter int NOUT = bdcr_pkg::NUM_OUT
)
(
    input wire logic clk, // 25 MHz clock
    input wire logic resetn, // Asynchronous reset, active low
    input wire logic [bdcr_pkg::ADDR_W-1:0] reg_addr, // Register offset
    input wire logic reg_wr, // Write strobe, one cycle
    input wire logic reg_rd, // Read strobe, one cycle
    input wire logic [bdcr_pkg::DATA_W-1:0] reg_wdata, // Write data
    output logic [bdcr_pkg::DATA_W-1:0] reg_rdata, // Read data, registered
    output logic reg_rvalid, // Read data valid pulse
    input wire logic driver_enable, // LED driver enabled
    input wire logic [NOUT-1:0] short_mask, // Per-output short mask
    input wire logic [NOUT-1:0] short_cmp, // Pin above threshold, async
    input wire logic [bdcr_pkg::STATE_W-1:0] live_state_code, // Main state
    input wire logic [bdcr_pkg::DATA_W-1:0] input_duty, // Measured duty
    input wire logic [bdcr_pkg::DATA_W-1:0] output_duty_code, // Out0 duty
    input wire logic [bdcr_pkg::CUR_W-1:0] output_current_dac_code, // Out0
    input wire logic [bdcr_pkg::BOOST_W-1:0] boost_voltage_code, // Boost
    input wire logic [2:0] detected_string_layout, // Layout code
    input wire logic [2:0] detected_switching_frequency, // Boost rate
    input wire logic [2:0] detected_dimming_frequency, // Dimming rate
    output logic [NOUT-1:0] external_supply_select, // 1 = external supply
    output logic [bdcr_pkg::THR_W-1:0] short_fault_threshold, // To comparator
    output logic [NOUT-1:0] short_fault // Short flags per output
);
    import bdcr_pkg::*;

    logic rst_meta_ff;
    logic rst_sync_ff;
    logic [DATA_W-1:0] supply_ff, nxt_supply;
    logic [DATA_W-1:0] short_cfg_ff, nxt_short_cfg;
    logic [DATA_W-1:0] rdata_ff, nxt_rdata;
    logic rvalid_ff, nxt_rvalid;
    logic [NOUT-1:0] cmp_meta_ff;
    logic [NOUT-1:0] cmp_sync_ff;
    logic [NOUT-1:0] fault_ff, nxt_fault;

    // Reset release through two flops so every flop leaves reset together
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end
        else
        begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    // Analog comparators are asynchronous to clk, so two-flop them
    always_ff @(posedge clk or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
        begin
            cmp_meta_ff <= '0;
            cmp_sync_ff <= '0;
        end
        else
        begin
            cmp_meta_ff <= short_cmp;
            cmp_sync_ff <= cmp_meta_ff;
        end
    end

    // Writes: only the two writable registers accept data
    always_comb
    begin
        nxt_supply = supply_ff;
        nxt_short_cfg = short_cfg_ff;
        // whole word stored, so reserved bits keep what software gave
        if (reg_wr && reg_addr == SUPPLY_SEL_OFS)
        begin
            nxt_supply = reg_wdata;
        end
        else if (reg_wr && reg_addr == SHORT_CFG_OFS)
        begin
            nxt_short_cfg = reg_wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
        begin
            supply_ff <= SUPPLY_SEL_RST;
            short_cfg_ff <= SHORT_CFG_RST;
        end
        else
        begin
            supply_ff <= nxt_supply;
            short_cfg_ff <= nxt_short_cfg;
        end
    end

    // select bits 15..10, output index ascends from bit 10
    // one steers the output to the external supply
    assign external_supply_select = supply_ff[EXT_SEL_LSB +: NOUT];
    // code passed on unchanged to the threshold comparator
    assign short_fault_threshold = short_cfg_ff[THR_LSB +: THR_W];

    // Short flags are live: they follow the comparator, not sticky
    always_comb
    begin
        // only while driver runs; masked outputs never flag
        nxt_fault = driver_enable ? (cmp_sync_ff & ~short_mask) : '0;
    end

    always_ff @(posedge clk or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
            fault_ff <= '0;
        else
            fault_ff <= nxt_fault;
    end

    assign short_fault = fault_ff;

    // Read mux; unmapped offsets and unused monitor bits read zero
    always_comb
    begin
        nxt_rvalid = reg_rd;
        nxt_rdata = rdata_ff;
        if (reg_rd)
        begin
            nxt_rdata = READ_ZERO;
            if (reg_addr == SUPPLY_SEL_OFS)
                nxt_rdata = supply_ff;
            else if (reg_addr == SHORT_CFG_OFS)
                nxt_rdata = short_cfg_ff;
            else if (reg_addr == STATE_MON_OFS)
                nxt_rdata[STATE_W-1:0] = live_state_code;
            else if (reg_addr == IN_DUTY_OFS)
                nxt_rdata = input_duty;
            // duty code applied to output 0
            else if (reg_addr == OUT_DUTY_OFS)
                nxt_rdata = output_duty_code;
            // current DAC code in bits 11..0
            else if (reg_addr == OUT_CUR_OFS)
                nxt_rdata[CUR_W-1:0] = output_current_dac_code;
            // code scaling lives in the analog boost block
            else if (reg_addr == BOOST_MON_OFS)
                nxt_rdata[BOOST_W-1:0] = boost_voltage_code;
            else if (reg_addr == STRAP_MON_OFS)
            begin
                nxt_rdata[LAYOUT_LSB +: CODE3_W] = detected_string_layout;
                nxt_rdata[SWRATE_LSB +: CODE3_W] =
                    detected_switching_frequency;
                nxt_rdata[DIMRATE_LSB +: CODE3_W] = detected_dimming_frequency;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
        begin
            rdata_ff <= '0;
            rvalid_ff <= 1'b0;
        end
        else
        begin
            rdata_ff <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
        end
    end

    assign reg_rdata = rdata_ff;
    assign reg_rvalid = rvalid_ff;

    // Checks next to the logic
    // One-step requests seen on the register bus
    sequence wr_supply_s;
        reg_wr && reg_addr == SUPPLY_SEL_OFS;
    endsequence

    sequence wr_short_cfg_s;
        reg_wr && reg_addr == SHORT_CFG_OFS;
    endsequence

    // Fault path steps: a short seen, then held through the sync delay
    sequence short_seen_s;
        driver_enable && (short_cmp & ~short_mask) != '0;
    endsequence

    sequence short_held_s;
        driver_enable && $stable(short_cmp) && $stable(short_mask);
    endsequence

    // Offsets the bank answers, kept apart from the mux it judges
    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        return a == SUPPLY_SEL_OFS || a == SHORT_CFG_OFS ||
            a == STATE_MON_OFS || a == IN_DUTY_OFS ||
            a == OUT_DUTY_OFS || a == OUT_CUR_OFS ||
            a == BOOST_MON_OFS || a == STRAP_MON_OFS;
    endfunction

    supply_write_a: assert property (
        @(posedge clk) disable iff (!rst_sync_ff)
        wr_supply_s |=> external_supply_select ==
            $past(reg_wdata[EXT_SEL_LSB +: NOUT]))
        else $error("supply select not stored");

    ro_write_a: assert property (
        @(posedge clk) disable iff (!rst_sync_ff)
        (reg_wr && reg_addr != SUPPLY_SEL_OFS && reg_addr != SHORT_CFG_OFS)
        |=> $stable(supply_ff) && $stable(short_cfg_ff))
        else $error("read-only write changed state");

    thr_write_a: assert property (
        @(posedge clk) disable iff (!rst_sync_ff)
        wr_short_cfg_s |=>
        short_fault_threshold == $past(reg_wdata[THR_LSB +: THR_W]))
        else $error("threshold not stored");

    thr_read_a: assert property (
        @(posedge clk) disable iff (!rst_sync_ff)
        (reg_rd && reg_addr == SHORT_CFG_OFS) |=>
        reg_rdata[THR_LSB +: THR_W] == $past(short_fault_threshold))
        else $error("threshold read wrong");

    fault_off_a: assert property (
        @(posedge clk) disable iff (!rst_sync_ff)
        !driver_enable |=> short_fault == '0)
        else $error("fault flagged while driver off");

    fault_mask_a: assert property (
        @(posedge clk) disable iff (!rst_sync_ff)
        ##1 (short_fault & $past(short_mask)) == '0)
        else $error("masked output flagged");

    fault_path_a: assert property (
        @(posedge clk) disable iff (!rst_sync_ff)
        short_seen_s ##1 short_held_s ##1 short_held_s
        |=> short_fault != '0)
        else $error("short fault not raised");

    state_read_a: assert property (
        @(posedge clk) disable iff (!rst_sync_ff)
        (reg_rd && reg_addr == STATE_MON_OFS) |=> reg_rvalid &&
        reg_rdata == {11'h000, $past(live_state_code)})
        else $error("state read wrong");

    duty_read_a: assert property (
        @(posedge clk) disable iff (!rst_sync_ff)
        (reg_rd && reg_addr == IN_DUTY_OFS) |=>
        reg_rdata == $past(input_duty))
        else $error("input duty read wrong");

    out_duty_read_a: assert property (
        @(posedge clk) disable iff (!rst_sync_ff)
        (reg_rd && reg_addr == OUT_DUTY_OFS) |=>
        reg_rdata == $past(output_duty_code))
        else $error("output duty read wrong");

    cur_read_a: assert property (
        @(posedge clk) disable iff (!rst_sync_ff)
        (reg_rd && reg_addr == OUT_CUR_OFS) |=>
        reg_rdata == {4'h0, $past(output_current_dac_code)})
        else $error("current code read wrong");

    boost_read_a: assert property (
        @(posedge clk) disable iff (!rst_sync_ff)
        (reg_rd && reg_addr == BOOST_MON_OFS) |=>
        reg_rdata == {5'h00, $past(boost_voltage_code)})
        else $error("boost code read wrong");

    strap_read_a: assert property (
        @(posedge clk) disable iff (!rst_sync_ff)
        (reg_rd && reg_addr == STRAP_MON_OFS) |=>
        reg_rdata == {7'h00, $past(detected_dimming_frequency),
        $past(detected_switching_frequency),
        $past(detected_string_layout)})
        else $error("strap read wrong");

    unmapped_read_a: assert property (
        @(posedge clk) disable iff (!rst_sync_ff)
        (reg_rd && !is_mapped(reg_addr)) |=> reg_rdata == READ_ZERO)
        else $error("unmapped read not zero");
endmodule

// File: testbench/backlight_diag_config_regs_bench.sv
// Self-checking bench for the backlight config and diagnostic bank
`timescale 1ns/10ps
module backlight_diag_config_regs_bench;
    import bdcr_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [9:0] reg_addr = 10'h000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata;
    logic reg_rvalid;
    logic driver_enable = 1'b0;
    logic [5:0] short_mask = 6'h00;
    logic [5:0] short_cmp = 6'h00;
    logic [4:0] live_state_code = 5'h00;
    logic [15:0] input_duty = 16'h0000;
    logic [15:0] output_duty_code = 16'h0000;
    logic [11:0] output_current_dac_code = 12'h000;
    logic [10:0] boost_voltage_code = 11'h000;
    logic [2:0] detected_string_layout = 3'h0;
    logic [2:0] detected_switching_frequency = 3'h0;
    logic [2:0] detected_dimming_frequency = 3'h0;
    logic [5:0] external_supply_select;
    logic [2:0] short_fault_threshold;
    logic [5:0] short_fault;
    logic [15:0] rd_val;
    int errors = 0;
    int total_checks = 0;

    bdcr_regs u_bdcr_regs (
        .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .driver_enable(driver_enable),
        .short_mask(short_mask), .short_cmp(short_cmp),
        .live_state_code(live_state_code), .input_duty(input_duty),
        .output_duty_code(output_duty_code),
        .output_current_dac_code(output_current_dac_code),
        .boost_voltage_code(boost_voltage_code),
        .detected_string_layout(detected_string_layout),
        .detected_switching_frequency(detected_switching_frequency),
        .detected_dimming_frequency(detected_dimming_frequency),
        .external_supply_select(external_supply_select),
        .short_fault_threshold(short_fault_threshold),
        .short_fault(short_fault));

    // 25 MHz clock
    initial
    begin
        forever #20 clk = ~clk;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Strobe launched just after an edge, taken at the next one
    task automatic wr(input logic [9:0] a, input logic [15:0] d);
        @(posedge clk);
        #1 reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clk);
        #1 reg_wr = 1'b0;
    endtask

    // Valid pulse stands one cycle only, so it is sampled right after the edge
    task automatic rd(input logic [9:0] a, output logic [15:0] d);
        @(posedge clk);
        #1 reg_rd = 1'b1;
        reg_addr = a;
        @(posedge clk);
        #1 reg_rd = 1'b0;
        chk({15'h0, reg_rvalid}, 16'h0001);
        d = reg_rdata;
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic test_reset_values;
        rd(10'h288, rd_val);
        chk(rd_val, 16'h01c0);
        chk({10'h0, external_supply_select}, 16'h0000);
        rd(10'h28a, rd_val);
        chk(rd_val, 16'h2882);
        chk({13'h0, short_fault_threshold}, 16'h0004);
        $display("reset values done");
    endtask

    // Walking one shows which output each select bit lands on
    task automatic test_supply_select;
        for (int i = 0; i < 6; i++)
        begin
            wr(10'h288, (16'h0400 << i) | 16'h01c0);
            chk({10'h0, external_supply_select}, 16'h0001 << i);
            rd(10'h288, rd_val);
            chk(rd_val, (16'h0400 << i) | 16'h01c0);
        end
        $display("supply select done");
    endtask

    task automatic test_threshold;
        for (int c = 0; c < 8; c++)
        begin
            wr(10'h28a, {4'h2, c[2:0], 9'h082});
            chk({13'h0, short_fault_threshold}, {13'h0, c[2:0]});
            rd(10'h28a, rd_val);
            chk(rd_val, {4'h2, c[2:0], 9'h082});
        end
        $display("threshold done");
    endtask

    task automatic test_monitors;
        logic [9:0] a [6];
        logic [15:0] e [6];
        a = '{10'h2a4, 10'h2a6, 10'h2a8, 10'h2aa, 10'h2ac, 10'h2ae};
        e = '{16'h0011, 16'ha5c3, 16'h5a3c, 16'h0fed, 16'h04b1, 16'h00f5};
        live_state_code = 5'h11;
        input_duty = 16'ha5c3;
        output_duty_code = 16'h5a3c;
        output_current_dac_code = 12'hfed;
        boost_voltage_code = 11'h4b1;
        detected_string_layout = 3'h5;
        detected_switching_frequency = 3'h6;
        detected_dimming_frequency = 3'h3;
        for (int i = 0; i < 6; i++)
        begin
            rd(a[i], rd_val);
            chk(rd_val, e[i]);
        end
        for (int s = 1; s < 18; s++)
        begin
            live_state_code = s[4:0];
            rd(10'h2a4, rd_val);
            chk(rd_val, {11'h0, s[4:0]});
        end
        // Writes to read-only and unmapped places must leave no trace
        wr(10'h2a4, 16'hffff);
        rd(10'h2a4, rd_val);
        chk(rd_val, 16'h0011);
        wr(10'h2b0, 16'hffff);
        rd(10'h288, rd_val);
        chk(rd_val, 16'h81c0);
        rd(10'h2b0, rd_val);
        chk(rd_val, 16'h0000);
        $display("monitors done");
    endtask

    // Comparator passes two sync flops, so the flag shows on the 3rd edge
    task automatic test_short_path;
        driver_enable = 1'b1;
        short_cmp = 6'h04;
        repeat (2) @(posedge clk);
        #1 chk({10'h0, short_fault}, 16'h0000);
        @(posedge clk);
        #1 chk({10'h0, short_fault}, 16'h0004);
        short_mask = 6'h04;
        @(posedge clk);
        #1 chk({10'h0, short_fault}, 16'h0000);
        short_mask = 6'h00;
        @(posedge clk);
        #1 chk({10'h0, short_fault}, 16'h0004);
        driver_enable = 1'b0;
        @(posedge clk);
        #1 chk({10'h0, short_fault}, 16'h0000);
        driver_enable = 1'b1;
        short_cmp = 6'h3f;
        short_mask = 6'h15;
        repeat (3) @(posedge clk);
        #1 chk({10'h0, short_fault}, 16'h002a);
        short_cmp = 6'h00;
        $display("short path done");
    endtask

    // Reset in mid-run must bring back the reset values of both registers
    task automatic test_mid_reset;
        @(posedge clk);
        #1 resetn = 1'b0;
        repeat (3) @(posedge clk);
        #1 chk({13'h0, short_fault_threshold}, 16'h0004);
        chk({10'h0, external_supply_select}, 16'h0000);
        resetn = 1'b1;
        repeat (3) @(posedge clk);
        #1 rd(10'h28a, rd_val);
        chk(rd_val, 16'h2882);
        rd(10'h288, rd_val);
        chk(rd_val, 16'h01c0);
        $display("mid-run reset done");
    endtask

    // Main sequence: reset held 16 cycles, then the scenarios
    initial
    begin
        repeat (16) @(posedge clk);
        #1 resetn = 1'b1;
        repeat (5) @(posedge clk);
        #1 test_reset_values();
        test_supply_select();
        test_threshold();
        test_monitors();
        test_mid_reset();
        test_short_path();
        report_and_stop();
    end

    // Watchdog: the run needs under 200 cycles, allow far more
    initial
    begin
        #80000;
        errors++;
        $display("BAD %0t watchdog expired", $time);
        report_and_stop();
    end
endmodule
